// file: logic/acc_cfg.svh
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// Register bus geometry
`define ACC_ADDR_W 4
`define ACC_DATA_W 8

// Register offsets
`define ACC_OFS_CTRL_B 4'h0
`define ACC_OFS_CSR 4'h1
`define ACC_OFS_PIN_OFF 4'h2
`define ACC_OFS_CHAN 4'h3
`define ACC_OFS_CONV_A 4'h4
`define ACC_OFS_IRQ_STATUS 4'h5
`define ACC_OFS_IRQ_ENABLE 4'h6
`define ACC_OFS_IRQ_CLEAR 4'h7

// Comparator control and status fields
`define ACC_CSR_DISABLE 7
`define ACC_CSR_BANDGAP 6
`define ACC_CSR_RESULT 5
`define ACC_CSR_FLAG 4
`define ACC_CSR_IRQ_EN 3
`define ACC_CSR_CAPTURE 2
`define ACC_CSR_MODE_HI 1
`define ACC_CSR_MODE_LO 0

// Converter fields
`define ACC_CTRL_B_MUX_EN 6
`define ACC_CONV_A_ENABLE 7
`define ACC_CHAN_SEL_HI 2
`define ACC_CHAN_COUNT 8

// Pin input disable fields
`define ACC_PIN_OFF_NEG 1
`define ACC_PIN_OFF_POS 0
`define ACC_PIN_COUNT 2
`define ACC_PIN_OFF_MASK 8'h03

// Interrupt register fields
`define ACC_IRQ_COMPARE 0

// Reset values
`define ACC_RST_BYTE 8'h00

// Analog level model
`define ACC_LEVEL_W 10
`define ACC_BANDGAP_LEVEL 10'h1c2

`endif

// file: logic/acc_pkg.sv
package acc_pkg;

	typedef enum logic [1:0] {
		ACC_EV_TOGGLE = 2'b00,
		ACC_EV_RESERVED = 2'b01,
		ACC_EV_FALL = 2'b10,
		ACC_EV_RISE = 2'b11
	} acc_event_mode_t;

	typedef logic [7:0] acc_byte_t;

endpackage

// file: logic/acc_top.sv
`include "acc_cfg.svh"

// What this block does
// - Result is high when selected positive level exceeds negative level
// - Raw comparison is synchronised; result lags one to two cycles
// - Mode 00 toggle, 10 falling, 11 rising, 01 reserved with no event
// - A matching result event sets the event flag at bit 4
// - Interrupt only while flag, enable bit 3 and global enable are set
// - Flag clears on vector acknowledge or a software write of one
// - Disable bit 7 powers the comparator off, writable at any time
// - Bandgap select bit 6 picks bandgap level, else the positive pin
// - Capture route bit 2 feeds result to timer capture, else none
// - Mux route on, converter off: channel select picks negative input
// - Mux route enable sits at bit 6 and needs converter switched off
// - Pin input disable bits turn buffers off and read port bits as zero
// - Bits 7 to 2 of the pin input disable register read zero
module acc_top (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [`ACC_ADDR_W-1:0] reg_addr_in,
	input wire logic [`ACC_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [`ACC_DATA_W-1:0] reg_rdata_out,
	input wire logic [`ACC_LEVEL_W-1:0] positive_input_pin_in,
	input wire logic [`ACC_LEVEL_W-1:0] negative_input_pin_in,
	input wire logic [`ACC_CHAN_COUNT*`ACC_LEVEL_W-1:0] converter_channel_pins_in,
	input wire logic [`ACC_PIN_COUNT-1:0] pin_digital_in,
	input wire logic global_irq_enable_in,
	input wire logic irq_ack_in,
	output logic compare_irq_out,
	output logic capture_trigger_out,
	output logic compare_power_off_out,
	output logic [`ACC_PIN_COUNT-1:0] input_buffer_off_out,
	output logic [`ACC_PIN_COUNT-1:0] port_input_out,
	output logic negative_from_mux_out,
	output logic [`ACC_CHAN_SEL_HI:0] negative_channel_out
);

	acc_pkg::acc_byte_t converter_control_b;
	acc_pkg::acc_byte_t converter_control_a;
	acc_pkg::acc_byte_t converter_channel_register;
	acc_pkg::acc_byte_t comparator_pin_input_disable;
	acc_pkg::acc_byte_t irq_enable;
	acc_pkg::acc_byte_t next_rdata;
	acc_pkg::acc_event_mode_t event_mode;

	logic compare_disable;
	logic bandgap_select;
	logic compare_event_flag;
	logic compare_irq_enable;
	logic capture_route_enable;
	logic sync_first;
	logic compare_result;
	logic result_prev;
	logic raw_compare;
	logic compare_event;
	logic mux_route_enable;
	logic converter_enable;
	logic use_mux;
	logic [`ACC_CHAN_SEL_HI:0] channel_select;
	logic [`ACC_LEVEL_W-1:0] positive_level;
	logic [`ACC_LEVEL_W-1:0] negative_level;
	logic [`ACC_LEVEL_W-1:0] channel_level [`ACC_CHAN_COUNT];
	logic wr_csr;
	logic wr_clear;
	logic flag_clear;
	logic irq_request;

	assign wr_csr = reg_write_in && (reg_addr_in == `ACC_OFS_CSR);
	assign wr_clear = reg_write_in && (reg_addr_in == `ACC_OFS_IRQ_CLEAR);

	assign mux_route_enable = converter_control_b[`ACC_CTRL_B_MUX_EN];
	assign converter_enable = converter_control_a[`ACC_CONV_A_ENABLE];
	assign channel_select = converter_channel_register[`ACC_CHAN_SEL_HI:0];

	// Split the channel bus into one level per channel
	genvar ch;
	generate
		for (ch = 0; ch < `ACC_CHAN_COUNT; ch++) begin : g_chan
			assign channel_level[ch] =
				converter_channel_pins_in[ch*`ACC_LEVEL_W +: `ACC_LEVEL_W];
		end
	endgenerate

	// Negative input select
	// The mux only steals the negative input while the converter is idle
	assign use_mux = mux_route_enable && !converter_enable;

	always_comb begin
		if (use_mux) begin
			negative_level = channel_level[channel_select];
		end else begin
			negative_level = negative_input_pin_in;
		end
	end

	always_comb begin
		if (bandgap_select) begin
			positive_level = `ACC_BANDGAP_LEVEL;
		end else begin
			positive_level = positive_input_pin_in;
		end
	end

	// Comparison, forced low while powered off
	always_comb begin
		if (compare_disable) begin
			raw_compare = 1'b0;
		end else begin
			raw_compare = (positive_level > negative_level);
		end
	end

	// Two-flop synchroniser
	// Levels move at any time, so only the second stage reads the first
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync_first <= 1'b0;
			compare_result <= 1'b0;
		end else begin
			sync_first <= raw_compare;
			compare_result <= sync_first;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			result_prev <= 1'b0;
		end else begin
			result_prev <= compare_result;
		end
	end

	always_comb begin
		case (event_mode)
			acc_pkg::ACC_EV_TOGGLE: begin
				compare_event = compare_result ^ result_prev;
			end
			acc_pkg::ACC_EV_FALL: begin
				compare_event = result_prev && !compare_result;
			end
			acc_pkg::ACC_EV_RISE: begin
				compare_event = compare_result && !result_prev;
			end
			acc_pkg::ACC_EV_RESERVED: begin
				compare_event = 1'b0;
			end
			default: begin
				compare_event = 1'b0;
			end
		endcase
	end

	// Clear sources for the event flag
	assign flag_clear = irq_ack_in
		|| (wr_csr && reg_wdata_in[`ACC_CSR_FLAG])
		|| (wr_clear && reg_wdata_in[`ACC_IRQ_COMPARE]);

	// Event flag, set wins over clear
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			compare_event_flag <= 1'b0;
		end else if (compare_event) begin
			compare_event_flag <= 1'b1;
		end else if (flag_clear) begin
			compare_event_flag <= 1'b0;
		end
	end

	// Control fields of the comparator control and status register
	// Mode changes are not guarded here; a stray event is the caller's risk
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			compare_disable <= 1'b0;
			bandgap_select <= 1'b0;
			compare_irq_enable <= 1'b0;
			capture_route_enable <= 1'b0;
			event_mode <= acc_pkg::ACC_EV_TOGGLE;
		end else if (wr_csr) begin
			compare_disable <= reg_wdata_in[`ACC_CSR_DISABLE];
			bandgap_select <= reg_wdata_in[`ACC_CSR_BANDGAP];
			compare_irq_enable <= reg_wdata_in[`ACC_CSR_IRQ_EN];
			capture_route_enable <= reg_wdata_in[`ACC_CSR_CAPTURE];
			event_mode <= acc_pkg::acc_event_mode_t'(
				reg_wdata_in[`ACC_CSR_MODE_HI:`ACC_CSR_MODE_LO]);
		end
	end

	// Converter control registers mirrored for the mux decision
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			converter_control_b <= `ACC_RST_BYTE;
			converter_control_a <= `ACC_RST_BYTE;
			converter_channel_register <= `ACC_RST_BYTE;
		end else if (reg_write_in) begin
			case (reg_addr_in)
				`ACC_OFS_CTRL_B: begin
					converter_control_b <= reg_wdata_in;
				end
				`ACC_OFS_CONV_A: begin
					converter_control_a <= reg_wdata_in;
				end
				`ACC_OFS_CHAN: begin
					converter_channel_register <= reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	// Pin input disable, upper bits never stored
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			comparator_pin_input_disable <= `ACC_RST_BYTE;
		end else if (reg_write_in && (reg_addr_in == `ACC_OFS_PIN_OFF)) begin
			comparator_pin_input_disable <= reg_wdata_in & `ACC_PIN_OFF_MASK;
		end
	end

	// Interrupt enable register
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_enable <= `ACC_RST_BYTE;
		end else if (reg_write_in && (reg_addr_in == `ACC_OFS_IRQ_ENABLE)) begin
			irq_enable <= reg_wdata_in;
		end
	end

	assign irq_request = compare_event_flag && compare_irq_enable
		&& irq_enable[`ACC_IRQ_COMPARE] && global_irq_enable_in;

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			compare_irq_out <= 1'b0;
		end else begin
			compare_irq_out <= irq_request;
		end
	end

	// Capture route to timer front end
	// The timer does its own noise cancelling, so the result goes out unfiltered
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			capture_trigger_out <= 1'b0;
		end else begin
			capture_trigger_out <= capture_route_enable && compare_result;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			compare_power_off_out <= 1'b0;
		end else begin
			compare_power_off_out <= compare_disable;
		end
	end

	// Mux route indication toward the converter mux
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			negative_from_mux_out <= 1'b0;
			negative_channel_out <= 3'h0;
		end else begin
			negative_from_mux_out <= use_mux;
			negative_channel_out <= channel_select;
		end
	end

	// Per-pin buffer disable and port read masking
	genvar pn;
	generate
		for (pn = 0; pn < `ACC_PIN_COUNT; pn++) begin : g_pin
			always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					input_buffer_off_out[pn] <= 1'b0;
					port_input_out[pn] <= 1'b0;
				end else begin
					input_buffer_off_out[pn] <=
						comparator_pin_input_disable[pn];
					port_input_out[pn] <= pin_digital_in[pn]
						&& !comparator_pin_input_disable[pn];
				end
			end
		end
	endgenerate

	// Read mux; write-only and unmapped offsets read zero
	always_comb begin
		next_rdata = `ACC_RST_BYTE;
		case (reg_addr_in)
			`ACC_OFS_CTRL_B: begin
				next_rdata = converter_control_b;
			end
			`ACC_OFS_CSR: begin
				next_rdata[`ACC_CSR_DISABLE] = compare_disable;
				next_rdata[`ACC_CSR_BANDGAP] = bandgap_select;
				next_rdata[`ACC_CSR_RESULT] = compare_result;
				next_rdata[`ACC_CSR_FLAG] = compare_event_flag;
				next_rdata[`ACC_CSR_IRQ_EN] = compare_irq_enable;
				next_rdata[`ACC_CSR_CAPTURE] = capture_route_enable;
				next_rdata[`ACC_CSR_MODE_HI:`ACC_CSR_MODE_LO] = event_mode;
			end
			`ACC_OFS_PIN_OFF: begin
				next_rdata = comparator_pin_input_disable;
			end
			`ACC_OFS_CHAN: begin
				next_rdata = converter_channel_register;
			end
			`ACC_OFS_CONV_A: begin
				next_rdata = converter_control_a;
			end
			`ACC_OFS_IRQ_STATUS: begin
				next_rdata[`ACC_IRQ_COMPARE] = compare_event_flag;
			end
			`ACC_OFS_IRQ_ENABLE: begin
				next_rdata = irq_enable;
			end
			default: begin
				next_rdata = `ACC_RST_BYTE;
			end
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= `ACC_RST_BYTE;
		end else if (reg_read_in) begin
			reg_rdata_out <= next_rdata;
		end else begin
			reg_rdata_out <= `ACC_RST_BYTE;
		end
	end

endmodule

// file: testbench/acc_top_props.sv
`include "acc_cfg.svh"
module acc_top_props (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic global_irq_enable_in,
	input wire logic irq_ack_in,
	input wire logic compare_irq_out,
	input wire logic compare_power_off_out,
	input wire logic [1:0] input_buffer_off_out,
	input wire logic [1:0] port_input_out,
	input wire logic [2:0] negative_channel_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	logic wr_csr;
	logic wr_chan;
	logic [2:0] chan_shadow;
	assign wr_csr = reg_write_in && reg_addr_in == `ACC_OFS_CSR;
	assign wr_chan = reg_write_in && reg_addr_in == `ACC_OFS_CHAN;
	// Last channel written; the copy lags it by up to two edges
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
		if (sys_rst_in)
			chan_shadow <= 3'h0;
		else if (wr_chan)
			chan_shadow <= reg_wdata_in[2:0];
	irq_global_gate_a:
	assert property (compare_irq_out |-> $past(global_irq_enable_in))
		else $error("irq without global enable");
	irq_global_drop_a:
	assert property ($fell(global_irq_enable_in) |=> !compare_irq_out)
		else $error("irq stays after global off");
	ack_clears_irq_a:
	assert property (irq_ack_in |-> ##[1:3] !compare_irq_out)
		else $error("irq stays after ack");
	pin_pad_zero_a:
	assert property ($past(reg_read_in) && $past(reg_addr_in) ==
		`ACC_OFS_PIN_OFF |-> reg_rdata_out[7:2] == 6'h00)
		else $error("unused pin bits read nonzero");
	buf_mask_a:
	assert property ((port_input_out & input_buffer_off_out) == 2'h0)
		else $error("disabled pin reads one");
	power_off_a:
	assert property (wr_csr && reg_wdata_in[7] |-> ##[1:2]
		compare_power_off_out)
		else $error("comparator not powered off");
	power_on_a:
	assert property (wr_csr && !reg_wdata_in[7] |-> ##[1:2]
		!compare_power_off_out)
		else $error("comparator not powered on");
	chan_copy_a:
	assert property (!$past(wr_chan) && !$past(wr_chan, 2) |->
		negative_channel_out == chan_shadow)
		else $error("channel copy wrong");
	cover property ($rose(compare_irq_out));
	cover property ($rose(compare_power_off_out));
	cover property (negative_channel_out == 3'h7);
endmodule
bind acc_top acc_top_props acc_top_props_i (
	.clk_sys_in(clk_sys_in),
	.sys_rst_in(sys_rst_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_write_in(reg_write_in),
	.reg_read_in(reg_read_in),
	.reg_rdata_out(reg_rdata_out),
	.global_irq_enable_in(global_irq_enable_in),
	.irq_ack_in(irq_ack_in),
	.compare_irq_out(compare_irq_out),
	.compare_power_off_out(compare_power_off_out),
	.input_buffer_off_out(input_buffer_off_out),
	.port_input_out(port_input_out),
	.negative_channel_out(negative_channel_out)
);

// file: testbench/acc_analog_model.sv
module acc_analog_model (
	input wire logic clk_sys_in,
	input wire logic capture_trigger_in,
	output logic [79:0] converter_channel_pins_out,
	output logic [1:0] pin_digital_out,
	output logic capture_hit_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic converter_power_reduce = 1'b0;
	// Channel k at 128k+64, so one level splits them
	always_comb
		for (int k = 0; k < 8; k++)
			converter_channel_pins_out[10*k+:10] =
				converter_power_reduce ? 10'h000 : 10'(128*k+64);
	// Timer capture interrupt enable kept set, so each trigger counts
	logic capture_irq_enable = 1'b1;
	assign capture_hit_out = capture_irq_enable && capture_trigger_in;
	// Pins change each cycle so a stale copy shows
	initial begin
		pin_digital_out = 2'b01;
		forever @(posedge clk_sys_in) pin_digital_out <= ~pin_digital_out;
	end
endmodule

// file: testbench/tb_acc_top.sv
`include "acc_cfg.svh"
module tb_acc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [3:0] reg_addr_in = 4'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_write_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic global_irq_enable_in = 1'b0;
	logic irq_ack_in = 1'b0;
	logic [9:0] positive_input_pin_in = 10'h000;
	logic [9:0] negative_input_pin_in = 10'h200;
	logic [79:0] converter_channel_pins_in;
	logic [1:0] pin_digital_in, input_buffer_off_out, port_input_out;
	logic [7:0] reg_rdata_out, v;
	logic compare_irq_out, capture_trigger_out, compare_power_off_out;
	logic negative_from_mux_out;
	logic capture_hit;
	logic [2:0] negative_channel_out;
	int mismatches = 0;
	int total_checks = 0;
	always #12.5 clk_sys_in = ~clk_sys_in;
	acc_top acc_top_i (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out),
		.positive_input_pin_in(positive_input_pin_in),
		.negative_input_pin_in(negative_input_pin_in),
		.converter_channel_pins_in(converter_channel_pins_in),
		.pin_digital_in(pin_digital_in),
		.global_irq_enable_in(global_irq_enable_in),
		.irq_ack_in(irq_ack_in),
		.compare_irq_out(compare_irq_out),
		.capture_trigger_out(capture_trigger_out),
		.compare_power_off_out(compare_power_off_out),
		.input_buffer_off_out(input_buffer_off_out),
		.port_input_out(port_input_out),
		.negative_from_mux_out(negative_from_mux_out),
		.negative_channel_out(negative_channel_out)
	);
	acc_analog_model acc_analog_model_i (
		.clk_sys_in(clk_sys_in),
		.capture_trigger_in(capture_trigger_out),
		.converter_channel_pins_out(converter_channel_pins_in),
		.pin_digital_out(pin_digital_in),
		.capture_hit_out(capture_hit)
	);
	task automatic chk(input string n, input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// Outputs are sampled mid-cycle, well clear of the launching edge
	task automatic look(input int n);
		cyc(n);
		@(negedge clk_sys_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_write_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys_in);
		reg_read_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_read_in <= 1'b0;
		@(negedge clk_sys_in);
		v = reg_rdata_out;
	endtask
	task automatic setp(input logic [9:0] p);
		@(posedge clk_sys_in);
		positive_input_pin_in <= p;
		look(4);
	endtask
	task automatic t_reset();
		@(posedge clk_sys_in);
		sys_rst_in <= 1'b1;
		positive_input_pin_in <= 10'h000;
		cyc(15);
		sys_rst_in <= 1'b0;
		for (int a = 0; a < 9; a++) begin
			rd(a == 8 ? 4'hf : 4'(a));
			chk("reset", v, 8'h00);
		end
	endtask
	task automatic t_pins();
		wr(`ACC_OFS_PIN_OFF, 8'hff);
		rd(`ACC_OFS_PIN_OFF);
		chk("pin reg", v, 8'h03);
		chk("buf off", 8'(input_buffer_off_out), 8'h03);
		chk("port", 8'(port_input_out), 8'h00);
		wr(`ACC_OFS_PIN_OFF, 8'h02);
		look(2);
		chk("buf neg", 8'(input_buffer_off_out), 8'h02);
		// Bit 0 shows the pin as it stood before the last edge
		chk("port", 8'(port_input_out), 8'(~pin_digital_in & 2'b01));
		wr(`ACC_OFS_PIN_OFF, 8'h00);
	endtask
	task automatic t_modes();
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(`ACC_OFS_CSR, {6'h04, m});
			setp(10'h300);
			rd(`ACC_OFS_CSR);
			chk("result", 8'(v[5]), 8'h01);
			chk("rise", 8'(v[4]), 8'(m == 2'b00 || m == 2'b11));
			wr(`ACC_OFS_CSR, {6'h04, m});
			setp(10'h000);
			rd(`ACC_OFS_CSR);
			chk("fall", 8'(v[4]), 8'(m == 2'b00 || m == 2'b10));
		end
	endtask
	task automatic t_irq();
		wr(`ACC_OFS_IRQ_ENABLE, 8'h01);
		wr(`ACC_OFS_CSR, 8'h1b);
		global_irq_enable_in <= 1'b1;
		setp(10'h300);
		chk("irq", 8'(compare_irq_out), 8'h01);
		rd(`ACC_OFS_IRQ_STATUS);
		chk("status", v, 8'h01);
		cyc(1);
		irq_ack_in <= 1'b1;
		cyc(1);
		irq_ack_in <= 1'b0;
		look(3);
		chk("ack", 8'(compare_irq_out), 8'h00);
		setp(10'h000);
		setp(10'h300);
		cyc(1);
		global_irq_enable_in <= 1'b0;
		look(2);
		chk("global", 8'(compare_irq_out), 8'h00);
		rd(`ACC_OFS_IRQ_STATUS);
		chk("held", v, 8'h01);
		wr(`ACC_OFS_IRQ_CLEAR, 8'h01);
		global_irq_enable_in <= 1'b1;
		look(3);
		chk("clear", 8'(compare_irq_out), 8'h00);
		rd(`ACC_OFS_IRQ_STATUS);
		chk("cleared", v, 8'h00);
		wr(`ACC_OFS_IRQ_ENABLE, 8'h00);
		wr(`ACC_OFS_CSR, 8'h10);
	endtask
	task automatic t_analog();
		wr(`ACC_OFS_CSR, 8'h40);
		negative_input_pin_in <= 10'h100;
		setp(10'h000);
		rd(`ACC_OFS_CSR);
		chk("bandgap", 8'(v[5]), 8'h01);
		wr(`ACC_OFS_CSR, 8'h04);
		negative_input_pin_in <= 10'h200;
		wr(`ACC_OFS_CTRL_B, 8'h40);
		setp(10'h1c0);
		for (int k = 0; k < 8; k++) begin
			wr(`ACC_OFS_CHAN, 8'(k));
			look(3);
			chk("chan", 8'(negative_channel_out), 8'(k));
			chk("mux", 8'(negative_from_mux_out), 8'h01);
			chk("capt", 8'(capture_trigger_out), 8'(k < 3));
			chk("timer", 8'(capture_hit), 8'(k < 3));
			rd(`ACC_OFS_CSR);
			chk("mux result", 8'(v[5]), 8'(k < 3));
		end
		wr(`ACC_OFS_CHAN, 8'h00);
		wr(`ACC_OFS_CONV_A, 8'h80);
		look(4);
		chk("mux off", 8'(negative_from_mux_out), 8'h00);
		rd(`ACC_OFS_CSR);
		chk("conv on", 8'(v[5]), 8'h00);
		wr(`ACC_OFS_CSR, 8'h00);
		setp(10'h3ff);
		chk("capt off", 8'(capture_trigger_out), 8'h00);
		wr(`ACC_OFS_CSR, 8'h80);
		look(4);
		chk("power", 8'(compare_power_off_out), 8'h01);
		rd(`ACC_OFS_CSR);
		chk("off", 8'(v[5]), 8'h00);
		wr(`ACC_OFS_CSR, 8'h00);
		cyc(4);
		rd(`ACC_OFS_CSR);
		chk("on", 8'(v[5]), 8'h01);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		t_reset();
		t_pins();
		t_modes();
		t_irq();
		t_analog();
		t_reset();
		give_verdict();
	end
	// Runs take under a thousand cycles
	initial begin
		cyc(6000);
		mismatches++;
		give_verdict();
	end
endmodule
